// *** pfs_defines.vh ***
// Register offsets, field positions and reset values of the pin function selector
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH
// Printed offsets are byte addresses only if all are multiples of four; they are not
`define PFS_P07_INDEX 16'ha057
`define PFS_P10_INDEX 16'ha058
`define PFS_ADDR_W 18
`define PFS_P07_ADDR 18'h2815c
`define PFS_P10_ADDR 18'h28160
`define PFS_SEL_RESET 8'h00
// Port 0 bit 7 fields
`define PFS_P07_TOUCH_KEY 7
`define PFS_P07_I2C_MASTER_CLK 6
`define PFS_P07_I2C_SLAVE2_CLK 5
`define PFS_P07_BUZZER 4
`define PFS_P07_SPI_CLK 3
// Port 1 bit 0 fields
`define PFS_P10_TOUCH_KEY 7
`define PFS_P10_UART2_RX 6
`define PFS_P10_UART1_RX 5
`define PFS_P10_CAPTURE4 4
`define PFS_P10_SPI_MOSI 3
// Fields common to both pins
`define PFS_IRQ_ONE 2
`define PFS_IRQ_ZERO 1
`define PFS_GPIO_EN 0
// AXI responses
`define PFS_RESP_OKAY 2'b00
`define PFS_RESP_SLVERR 2'b10
`endif

// *** pfs_pin_function_select.v ***
// Function selector and AXI4-Lite register slave for port 0 bit 7 and port 1 bit 0
// Operation
// - Port 0 bit 7 select register, reset zero
// - Port 1 bit 0 select register, reset zero
// - SPI clock select joins pin to SPI clock
// - Interrupt-one bit feeds pin into interrupt one
// - Interrupt-zero bit feeds pin into interrupt zero
// - Many pins, and both interrupts, allowed together
// - GPIO enable hands pin to GPIO, off at reset
// - Second UART receive taken from port 1 bit 0
// - First UART receive taken from port 1 bit 0
// - Capture channel 4 joined to port 1 bit 0
// - MOSI select joins pin to SPI MOSI
`timescale 1ns/1ps
`include "pfs_defines.vh"
module pfs_pin_function_select
(
  // Clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  // AXI4-Lite write address
  input wire [`PFS_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [`PFS_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Port 0 bit 7 pad
  input wire p07_pad_in,
  output wire p07_pad_out,
  output wire p07_pad_oe,
  // Port 1 bit 0 pad
  input wire p10_pad_in,
  output wire p10_pad_out,
  output wire p10_pad_oe,
  // GPIO controller, per pin
  input wire p07_gpio_out,
  input wire p07_gpio_oe,
  output wire p07_gpio_in,
  input wire p10_gpio_out,
  input wire p10_gpio_oe,
  output wire p10_gpio_in,
  // Touch key sense enables
  output wire touch_key_7_enable,
  output wire touch_key_8_enable,
  // I2C master clock line, open drain
  input wire i2c_master_clock_low,
  output wire i2c_master_clock_in,
  // I2C second slave clock line, open drain
  input wire i2c_slave_two_clock_low,
  output wire i2c_slave_two_clock_in,
  // Buzzer waveform
  input wire buzzer_wave,
  // SPI clock
  input wire spi_clock_out,
  input wire spi_clock_oe,
  output wire spi_clock_in,
  // SPI MOSI
  input wire spi_mosi_out,
  input wire spi_mosi_oe,
  output wire spi_mosi_in,
  // UART receive inputs
  output wire second_uart_rx,
  output wire first_uart_rx,
  // Capture/compare module 4 external I/O
  input wire capture4_out,
  input wire capture4_oe,
  output wire capture4_in,
  // Shared pin interrupt condition inputs
  output wire shared_pin_irq_zero_src,
  output wire shared_pin_irq_one_src
);

  // Select registers
  reg [7:0] p07_sel_q;
  reg [7:0] p07_sel_d;
  reg [7:0] p10_sel_q;
  reg [7:0] p10_sel_d;
  // Write channel holding state
  reg aw_held_q;
  reg [`PFS_ADDR_W-1:0] aw_addr_q;
  reg w_held_q;
  reg [7:0] w_data_q;
  reg w_lane0_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  // Read channel state
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  // Write fires once both halves are held and no response is pending
  wire wr_fire;
  wire wr_hit;
  // Word index of each address; the register map is laid out in indices
  wire [`PFS_ADDR_W-3:0] aw_word;
  wire [`PFS_ADDR_W-3:0] ar_word;

  // Each half is accepted once, then held until the response goes out.
  // Readies drop while clk_en is low, else a beat would be lost by frozen flops.
  // Limitation: a master must not take a response while clk_en is low,
  // as the frozen valid would then be offered a second time.
  assign s_axi_awready = clk_en & ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = clk_en & ~w_held_q & ~bvalid_q;
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign aw_word = aw_addr_q[`PFS_ADDR_W-1:2];
  assign ar_word = s_axi_araddr[`PFS_ADDR_W-1:2];
  assign wr_hit = (aw_word == `PFS_P07_INDEX) | (aw_word == `PFS_P10_INDEX);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  // One read at a time: address taken only while no data is pending
  assign s_axi_arready = clk_en & ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Next register values; only byte lane 0 carries the 8-bit field
  always @*
  begin
    p07_sel_d = p07_sel_q;
    p10_sel_d = p10_sel_q;
    if (wr_fire && w_lane0_q)
    begin
      // Plain storage: every bit reads back as written
      if (aw_word == `PFS_P07_INDEX)
        p07_sel_d = w_data_q;
      else if (aw_word == `PFS_P10_INDEX)
        p10_sel_d = w_data_q;
    end
  end

  // Register and bus state; clk_en low freezes everything
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // All selects clear, so GPIO and every function start disabled
      p07_sel_q <= `PFS_SEL_RESET;
      p10_sel_q <= `PFS_SEL_RESET;
      aw_held_q <= 1'b0;
      aw_addr_q <= {`PFS_ADDR_W{1'b0}};
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end
    else if (clk_en)
    begin
      p07_sel_q <= p07_sel_d;
      p10_sel_q <= p10_sel_d;
      // Capture write address
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      // Capture write data
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      // Issue the response and free both halves
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
      // Read: bits above the byte read zero, unmapped gives SLVERR
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_q <= 1'b1;
        if (ar_word == `PFS_P07_INDEX)
        begin
          rdata_q <= {24'h00_0000, p07_sel_q};
          rresp_q <= `PFS_RESP_OKAY;
        end
        else if (ar_word == `PFS_P10_INDEX)
        begin
          rdata_q <= {24'h00_0000, p10_sel_q};
          rresp_q <= `PFS_RESP_OKAY;
        end
        else
        begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `PFS_RESP_SLVERR;
        end
      end
      else if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // Port 0 bit 7 pad driver. Fixed priority below is an implementation accident
  // only; software must not set two driving functions at once.
  reg p07_out;
  reg p07_oe;
  always @*
  begin
    p07_out = 1'b0;
    p07_oe = 1'b0;
    if (p07_sel_q[`PFS_P07_SPI_CLK])
    begin
      p07_out = spi_clock_out;
      p07_oe = spi_clock_oe;
    end
    else if (p07_sel_q[`PFS_P07_BUZZER])
    begin
      p07_out = buzzer_wave;
      p07_oe = 1'b1;
    end
    else if (p07_sel_q[`PFS_P07_I2C_MASTER_CLK] | p07_sel_q[`PFS_P07_I2C_SLAVE2_CLK])
    begin
      // Open drain: only ever pull low, the bus pulls high
      p07_out = 1'b0;
      p07_oe = (p07_sel_q[`PFS_P07_I2C_MASTER_CLK] & i2c_master_clock_low) |
               (p07_sel_q[`PFS_P07_I2C_SLAVE2_CLK] & i2c_slave_two_clock_low);
    end
    else if (p07_sel_q[`PFS_GPIO_EN])
    begin
      p07_out = p07_gpio_out;
      p07_oe = p07_gpio_oe;
    end
  end
  assign p07_pad_out = p07_out;
  assign p07_pad_oe = p07_oe;

  // Port 1 bit 0 pad driver; receive selects are input only
  reg p10_out;
  reg p10_oe;
  always @*
  begin
    p10_out = 1'b0;
    p10_oe = 1'b0;
    if (p10_sel_q[`PFS_P10_SPI_MOSI])
    begin
      p10_out = spi_mosi_out;
      p10_oe = spi_mosi_oe;
    end
    else if (p10_sel_q[`PFS_P10_CAPTURE4])
    begin
      p10_out = capture4_out;
      p10_oe = capture4_oe;
    end
    else if (p10_sel_q[`PFS_GPIO_EN])
    begin
      p10_out = p10_gpio_out;
      p10_oe = p10_gpio_oe;
    end
  end
  assign p10_pad_out = p10_out;
  assign p10_pad_oe = p10_oe;

  // Inputs to peripherals; deselected I2C and UART receivers see idle high, the others see low
  assign spi_clock_in = p07_sel_q[`PFS_P07_SPI_CLK] ? p07_pad_in : 1'b0;
  assign i2c_master_clock_in = p07_sel_q[`PFS_P07_I2C_MASTER_CLK] ? p07_pad_in : 1'b1;
  assign i2c_slave_two_clock_in = p07_sel_q[`PFS_P07_I2C_SLAVE2_CLK] ? p07_pad_in : 1'b1;
  assign spi_mosi_in = p10_sel_q[`PFS_P10_SPI_MOSI] ? p10_pad_in : 1'b0;
  assign capture4_in = p10_sel_q[`PFS_P10_CAPTURE4] ? p10_pad_in : 1'b0;
  assign second_uart_rx = p10_sel_q[`PFS_P10_UART2_RX] ? p10_pad_in : 1'b1;
  assign first_uart_rx = p10_sel_q[`PFS_P10_UART1_RX] ? p10_pad_in : 1'b1;
  assign p07_gpio_in = p07_sel_q[`PFS_GPIO_EN] ? p07_pad_in : 1'b0;
  assign p10_gpio_in = p10_sel_q[`PFS_GPIO_EN] ? p10_pad_in : 1'b0;

  // Touch keys; key 8 also needs analog enable elsewhere
  assign touch_key_7_enable = p07_sel_q[`PFS_P07_TOUCH_KEY];
  assign touch_key_8_enable = p10_sel_q[`PFS_P10_TOUCH_KEY];

  // Shared interrupt conditions: OR of every enabled pin, each pin may feed both
  assign shared_pin_irq_one_src = (p07_sel_q[`PFS_IRQ_ONE] & p07_pad_in) |
                                  (p10_sel_q[`PFS_IRQ_ONE] & p10_pad_in);
  assign shared_pin_irq_zero_src = (p07_sel_q[`PFS_IRQ_ZERO] & p07_pad_in) |
                                   (p10_sel_q[`PFS_IRQ_ZERO] & p10_pad_in);

endmodule // pfs_pin_function_select

// *** pfs_pin_function_select_asserts.sv ***
// Port checker for the pin function selector
`timescale 1ns/1ps
module pfs_pin_function_select_asserts
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pads and routed functions
  input wire p07_pad_in,
  input wire p10_pad_in,
  input wire p07_pad_oe,
  input wire p07_gpio_in,
  input wire first_uart_rx,
  input wire shared_pin_irq_zero_src
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  a_gpio_pass: assert property (p07_gpio_in |-> p07_pad_in)
    else $error("gpio input wrong");
  a_uart_pass: assert property (!first_uart_rx |-> !p10_pad_in)
    else $error("uart input wrong");
  a_irq_level: assert property (shared_pin_irq_zero_src |-> p07_pad_in || p10_pad_in)
    else $error("irq source wrong");
  // Reset is the cause here, so it cannot also disable the check
  a_reset_clear:
    assert property (disable iff (1'b0) !aresetn |=> !p07_pad_oe && first_uart_rx)
    else $error("reset state wrong");
endmodule // pfs_pin_function_select_asserts

// *** pfs_pad_world.sv ***
// Outside world at the two pads
`timescale 1ns/1ps
module pfs_pad_world
(
  // Chip drive
  input wire p07_pad_out,
  input wire p07_pad_oe,
  input wire p10_pad_out,
  input wire p10_pad_oe,
  // Outside levels, p07 then p10
  input wire [1:0] pad_ext,
  // Resolved pad levels
  output wire p07_pad_in,
  output wire p10_pad_in
);
  // Chip drive wins; an open-drain clock only ever pulls low
  assign p07_pad_in = p07_pad_oe ? p07_pad_out : pad_ext[1];
  assign p10_pad_in = p10_pad_oe ? p10_pad_out : pad_ext[0];
endmodule // pfs_pad_world

// *** pin_function_select_p07_p10_bench.sv ***
// Self-checking bench for the pin function selector
`timescale 1ns/1ps
`include "pfs_defines.vh"
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module pin_function_select_p07_p10_bench;
  typedef struct packed {logic [7:0] r7, r10; logic [1:0] ext; logic [12:0] src;
    logic [16:0] obs;} pfs_row_t;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] pad_ext, wr_resp;
  logic [12:0] src;
  int fails, cmp_count;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire p07_pad_in, p07_pad_out, p07_pad_oe, p10_pad_in, p10_pad_out, p10_pad_oe;
  wire p07_gpio_in, p10_gpio_in, touch_key_7_enable, touch_key_8_enable, capture4_in;
  wire i2c_master_clock_in, i2c_slave_two_clock_in, spi_clock_in, spi_mosi_in;
  wire second_uart_rx, first_uart_rx, shared_pin_irq_zero_src, shared_pin_irq_one_src;
  wire p07_gpio_out, p07_gpio_oe, p10_gpio_out, p10_gpio_oe, i2c_master_clock_low;
  wire i2c_slave_two_clock_low, buzzer_wave, spi_clock_out, spi_clock_oe;
  wire spi_mosi_out, spi_mosi_oe, capture4_out, capture4_oe;
  // Peripheral side drive comes from one vector set per row
  assign {p07_gpio_out, p07_gpio_oe, p10_gpio_out, p10_gpio_oe, i2c_master_clock_low,
    i2c_slave_two_clock_low, buzzer_wave, spi_clock_out, spi_clock_oe, spi_mosi_out,
    spi_mosi_oe, capture4_out, capture4_oe} = src;
  // Pad levels rather than raw pad_out, which means nothing while released
  wire [16:0] obs = {p07_pad_in, p07_pad_oe, p10_pad_in, p10_pad_oe, shared_pin_irq_zero_src,
    shared_pin_irq_one_src, first_uart_rx, second_uart_rx, i2c_master_clock_in,
    i2c_slave_two_clock_in, spi_clock_in, spi_mosi_in, capture4_in, p07_gpio_in,
    p10_gpio_in, touch_key_7_enable, touch_key_8_enable};
  // Select values, outside levels, peripheral drive, expected observation
  // Each row sets at most one driving function per pin
  // Key 8 analog enable sits outside this block and is taken as set
  pfs_row_t rows [8] = '{
    {8'h00, 8'h00, 2'b11, 13'h0000, 17'h14780},
    {8'h88, 8'h80, 2'b01, 13'h0030, 17'h1c7c3},
    {8'h10, 8'h10, 2'b00, 13'h0043, 17'h1e790},
    {8'h40, 8'h08, 2'b11, 13'h0104, 17'h0a680},
    {8'h20, 8'h00, 2'b11, 13'h0080, 17'h0c700},
    {8'h01, 8'h01, 2'b01, 13'h1800, 17'h1c78c},
    {8'h06, 8'h02, 2'b01, 13'h0000, 17'h05780},
    {8'h06, 8'h62, 2'b10, 13'h0000, 17'h11980}};
  pfs_pin_function_select pfs_pin_function_select_inst (.*);
  pfs_pad_world pfs_pad_world_inst (.*);
  // One write, both halves offered together, each released when taken
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    wr_resp = s_axi_bresp;
  endtask
  // One read, compared with the expected word and response
  task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK({s_axi_rresp, s_axi_rdata}, {er, e})
  endtask
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    report_and_stop();
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    clk_en = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 72'h0;
    {pad_ext, src} = 15'h6000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PFS_P07_ADDR, 32'h0, `PFS_RESP_OKAY);
    rd(`PFS_P10_ADDR, 32'h0, `PFS_RESP_OKAY);
    foreach (rows[i])
    begin
      wr(`PFS_P07_ADDR, {24'h0, rows[i].r7}, 4'hf);
      wr(`PFS_P10_ADDR, {24'h0, rows[i].r10}, 4'hf);
      {pad_ext, src} <= {rows[i].ext, rows[i].src};
      @(posedge aclk);
      #1;
      `CHK(obs, rows[i].obs)
      rd(`PFS_P07_ADDR, {24'h0, rows[i].r7}, `PFS_RESP_OKAY);
      rd(`PFS_P10_ADDR, {24'h0, rows[i].r10}, `PFS_RESP_OKAY);
    end
    // Unmapped place, masked byte, upper data bits
    wr(18'h28164, 32'hff, 4'hf);
    `CHK(wr_resp, `PFS_RESP_SLVERR)
    rd(18'h28164, 32'h0, `PFS_RESP_SLVERR);
    wr(`PFS_P07_ADDR, 32'h3, 4'he);
    `CHK(wr_resp, `PFS_RESP_OKAY)
    rd(`PFS_P07_ADDR, 32'h6, `PFS_RESP_OKAY);
    wr(`PFS_P10_ADDR, 32'hffffff41, 4'hf);
    rd(`PFS_P10_ADDR, 32'h41, `PFS_RESP_OKAY);
    // Clock enable low: the bus stalls, the write lands once it returns
    clk_en <= 1'b0;
    fork
      wr(`PFS_P07_ADDR, 32'h5a, 4'h1);
      begin
        repeat (4) @(posedge aclk);
        `CHK({s_axi_awready, s_axi_wready, s_axi_bvalid}, 3'b000)
        clk_en <= 1'b1;
      end
    join
    `CHK(wr_resp, `PFS_RESP_OKAY)
    rd(`PFS_P07_ADDR, 32'h5a, `PFS_RESP_OKAY);
    // Reset again in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PFS_P07_ADDR, 32'h0, `PFS_RESP_OKAY);
    rd(`PFS_P10_ADDR, 32'h0, `PFS_RESP_OKAY);
    report_and_stop();
  end
endmodule // pin_function_select_p07_p10_bench
bind pfs_pin_function_select pfs_pin_function_select_asserts pfs_chk_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .p07_pad_in(p07_pad_in),
  .p10_pad_in(p10_pad_in),
  .p07_pad_oe(p07_pad_oe),
  .p07_gpio_in(p07_gpio_in),
  .first_uart_rx(first_uart_rx),
  .shared_pin_irq_zero_src(shared_pin_irq_zero_src)
);
